// *** hlt_pkg.sv ***
// Constants, codes and carrier types for the hardware-limit timer block
package hlt_pkg;

  // Widths
  localparam int unsigned HLT_CNT_W = 8;
  localparam int unsigned HLT_POST_W = 4;
  localparam int unsigned HLT_MODE_W = 5;
  localparam int unsigned HLT_SEL_W = 5;
  localparam int unsigned HLT_NUM_SRC = 32;

  // Reset values and increment steps
  localparam logic [7:0] HLT_COUNT_RST = 8'H00;
  localparam logic [7:0] HLT_PERIOD_RST = 8'HFF;
  localparam logic [3:0] HLT_POST_RST = 4'H0;
  localparam logic [7:0] HLT_COUNT_ONE = 8'H01;
  localparam logic [3:0] HLT_POST_ONE = 4'H1;

  // Trigger timing the source of the external input must respect
  localparam int unsigned HLT_EDGE_GAP_CYC = 6;
  localparam int unsigned HLT_LEVEL_MIN_CYC = 3;

  // Mode groups, mode bits 4:3
  localparam logic [1:0] HLT_GRP_FREE = 2'H0;
  localparam logic [1:0] HLT_GRP_ONESHOT = 2'H1;
  localparam logic [1:0] HLT_GRP_MONO = 2'H2;

  // Free-running sub-modes, mode bits 2:0
  localparam logic [2:0] HLT_FR_SW_GATE = 3'H0;
  localparam logic [2:0] HLT_FR_GATE_HI = 3'H1;
  localparam logic [2:0] HLT_FR_GATE_LO = 3'H2;
  localparam logic [2:0] HLT_FR_ANY_RST = 3'H3;
  localparam logic [2:0] HLT_FR_RISE_RST = 3'H4;
  localparam logic [2:0] HLT_FR_FALL_RST = 3'H5;
  localparam logic [2:0] HLT_FR_LOW_RST = 3'H6;
  localparam logic [2:0] HLT_FR_HIGH_RST = 3'H7;

  // One-shot sub-modes
  localparam logic [2:0] HLT_OS_SW_START = 3'H0;
  localparam logic [2:0] HLT_OS_RISE_START = 3'H1;
  localparam logic [2:0] HLT_OS_FALL_START = 3'H2;
  localparam logic [2:0] HLT_OS_ANY_START = 3'H3;
  localparam logic [2:0] HLT_OS_RISE_RISE = 3'H4;
  localparam logic [2:0] HLT_OS_FALL_FALL = 3'H5;
  localparam logic [2:0] HLT_OS_RISE_LOW = 3'H6;
  localparam logic [2:0] HLT_OS_FALL_HIGH = 3'H7;

  // Monostable and level one-shot sub-modes
  localparam logic [2:0] HLT_MS_RISE_START = 3'H1;
  localparam logic [2:0] HLT_MS_FALL_START = 3'H2;
  localparam logic [2:0] HLT_MS_ANY_START = 3'H3;
  localparam logic [2:0] HLT_LV_HIGH_RUN = 3'H6;
  localparam logic [2:0] HLT_LV_LOW_RUN = 3'H7;

  // Edge selection codes for the edge function
  localparam logic [1:0] HLT_EDGE_NONE = 2'H0;
  localparam logic [1:0] HLT_EDGE_RISE = 2'H1;
  localparam logic [1:0] HLT_EDGE_FALL = 2'H2;
  localparam logic [1:0] HLT_EDGE_ANY = 2'H3;

  // Software control of the timer
  typedef struct packed {
    logic ctrl_wr;
    logic on_wdata;
    logic [HLT_MODE_W-1:0] mode;
    logic [HLT_POST_W-1:0] postscale_select;
  } hlt_ctrl_t;

  // Software write of one 8-bit value
  typedef struct packed {
    logic wr;
    logic [HLT_CNT_W-1:0] wdata;
  } hlt_wr_t;

  // Time base handed to the PWM unit
  typedef struct packed {
    logic [HLT_CNT_W-1:0] count_value;
    logic [HLT_CNT_W-1:0] period_value;
    logic period_match;
    logic counting;
  } hlt_pwm_t;

  // Synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic level_prev;
  } hlt_sync_t;

  // Timer state
  typedef struct packed {
    logic [HLT_CNT_W-1:0] count;
    logic [HLT_CNT_W-1:0] period;
    logic [HLT_POST_W-1:0] post_cnt;
    logic on;
    logic started;
    logic pulse;
  } hlt_state_t;

endpackage

// *** hlt_ers_sync.sv ***
// Three-stage synchroniser and edge detector for the external reset input
`timescale 1ns/100ps
module hlt_ers_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Asynchronous input
  input wire logic async_in,
  // Filtered level and one-cycle edge pulses
  output logic level,
  output logic rise,
  output logic fall
);

  hlt_pkg::hlt_sync_t st_q;
  hlt_pkg::hlt_sync_t st_d;

  // Next state: level changes only once stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.level = st_q.s2;
    end
    st_d.level_prev = st_q.level;
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Edges from successive filtered samples
  assign level = st_q.level;
  assign rise = st_q.level & ~st_q.level_prev;
  assign fall = ~st_q.level & st_q.level_prev;

endmodule

// *** hlt_timer.sv ***
// Mode control, count, period and postscaler of the hardware-limit timer
//
// What this block does
// - Match pulse one clock when postscaler equals select
// - Postscaler advances on every count-period match
// - Count and match timing go to PWM unit
// - Match pulse exported for other peripherals
// - External input chosen by reset-source select
// - Mode field selects the timer behaviour
// - External triggers ignored during debug freeze
// - Software and hardware gate free-running modes
// - Free-running with edge reset of count
// - Free-running with level reset, counting otherwise
// - Software-start one-shot stops at period match
// - One-shot started by chosen external edge
// - One-shot edge start, same edge resets
// - One-shot edge start with level reset
// - Monostable edge start, stops at zero, keeps enable
// - Level one-shot modes; other codes reserved
// - Cleared enable needs fresh edge to resume
// - One-shot match clears enable, stops at zero
// - Count increments, wraps to zero after match
// - Reset clears count, period to all ones
// - Control and count writes and resets clear the postscaler
// - Postscaler cleared after emitting match pulse
`timescale 1ns/100ps
module hlt_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Software control, enable, mode and postscale select
  input wire hlt_pkg::hlt_ctrl_t ctrl,
  // Software writes of count and period
  input wire hlt_pkg::hlt_wr_t count_wr,
  input wire hlt_pkg::hlt_wr_t period_wr,
  // Debug freeze
  input wire logic debug_freeze,
  // External reset sources and their selection
  input wire logic [hlt_pkg::HLT_NUM_SRC-1:0] ext_reset_sources,
  input wire logic [hlt_pkg::HLT_SEL_W-1:0] reset_source_select,
  // Status back to software
  output logic on_status,
  // Time base for the PWM unit
  output hlt_pkg::hlt_pwm_t pwm_base,
  // Postscaled period match pulse
  output logic period_match_pulse,
  // External reset currently acting on the count
  output logic ers_reset_active
);

  hlt_pkg::hlt_state_t st_q;
  hlt_pkg::hlt_state_t st_d;

  logic ext_reset_input;
  logic ers_level;
  logic ers_rise;
  logic ers_fall;

  // Pick the external reset source for this instance
  assign ext_reset_input = ext_reset_sources[reset_source_select];

  // Synchronise the selected input into the timer clock domain
  hlt_ers_sync u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in(ext_reset_input),
    .level(ers_level),
    .rise(ers_rise),
    .fall(ers_fall)
  );

  // True when the chosen edge kind is seen
  function automatic logic edge_hit(input logic [1:0] kind,
                                    input logic r,
                                    input logic f);
    logic hit;
    hit = 1'b0;
    case (kind)
      hlt_pkg::HLT_EDGE_RISE: hit = r;
      hlt_pkg::HLT_EDGE_FALL: hit = f;
      hlt_pkg::HLT_EDGE_ANY: hit = r | f;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Decoded behaviour of the current mode
  logic [1:0] grp;
  logic [2:0] sub;
  logic [1:0] start_kind;
  logic [1:0] rst_edge_kind;
  logic gate_ok;
  logic lvl_rst;
  logic rst_needs_start;
  logic one_shot;
  logic mono;
  logic reserved;
  logic rise_v;
  logic fall_v;
  logic start_ev;
  logic rst_active;
  logic run;
  logic match;
  logic clr_post;

  // Mode decode, triggers, count and postscaler next state
  always_comb begin
    st_d = st_q;
    grp = ctrl.mode[4:3];
    sub = ctrl.mode[2:0];
    start_kind = hlt_pkg::HLT_EDGE_NONE;
    rst_edge_kind = hlt_pkg::HLT_EDGE_NONE;
    gate_ok = 1'b1;
    lvl_rst = 1'b0;
    rst_needs_start = 1'b0;
    one_shot = 1'b0;
    mono = 1'b0;
    reserved = 1'b0;
    // Triggers are masked while frozen
    rise_v = ers_rise & ~debug_freeze;
    fall_v = ers_fall & ~debug_freeze;

    // Behaviour chosen by the mode field
    case (grp)
      hlt_pkg::HLT_GRP_FREE: begin
        case (sub)
          hlt_pkg::HLT_FR_SW_GATE: gate_ok = 1'b1;
          hlt_pkg::HLT_FR_GATE_HI: gate_ok = ers_level;
          hlt_pkg::HLT_FR_GATE_LO: gate_ok = ~ers_level;
          hlt_pkg::HLT_FR_ANY_RST: begin
            rst_edge_kind = hlt_pkg::HLT_EDGE_ANY;
          end
          hlt_pkg::HLT_FR_RISE_RST: begin
            rst_edge_kind = hlt_pkg::HLT_EDGE_RISE;
          end
          hlt_pkg::HLT_FR_FALL_RST: begin
            rst_edge_kind = hlt_pkg::HLT_EDGE_FALL;
          end
          hlt_pkg::HLT_FR_LOW_RST: begin
            gate_ok = ers_level;
            lvl_rst = ~ers_level;
          end
          default: begin
            gate_ok = ~ers_level;
            lvl_rst = ers_level;
          end
        endcase
      end
      hlt_pkg::HLT_GRP_ONESHOT: begin
        one_shot = 1'b1;
        rst_needs_start = 1'b1;
        case (sub)
          hlt_pkg::HLT_OS_SW_START: begin
            start_kind = hlt_pkg::HLT_EDGE_NONE;
          end
          hlt_pkg::HLT_OS_RISE_START: begin
            start_kind = hlt_pkg::HLT_EDGE_RISE;
          end
          hlt_pkg::HLT_OS_FALL_START: begin
            start_kind = hlt_pkg::HLT_EDGE_FALL;
          end
          hlt_pkg::HLT_OS_ANY_START: begin
            start_kind = hlt_pkg::HLT_EDGE_ANY;
          end
          hlt_pkg::HLT_OS_RISE_RISE: begin
            start_kind = hlt_pkg::HLT_EDGE_RISE;
            rst_edge_kind = hlt_pkg::HLT_EDGE_RISE;
          end
          hlt_pkg::HLT_OS_FALL_FALL: begin
            start_kind = hlt_pkg::HLT_EDGE_FALL;
            rst_edge_kind = hlt_pkg::HLT_EDGE_FALL;
          end
          hlt_pkg::HLT_OS_RISE_LOW: begin
            start_kind = hlt_pkg::HLT_EDGE_RISE;
            lvl_rst = ~ers_level;
          end
          default: begin
            start_kind = hlt_pkg::HLT_EDGE_FALL;
            lvl_rst = ers_level;
          end
        endcase
      end
      hlt_pkg::HLT_GRP_MONO: begin
        case (sub)
          hlt_pkg::HLT_MS_RISE_START: begin
            mono = 1'b1;
            start_kind = hlt_pkg::HLT_EDGE_RISE;
          end
          hlt_pkg::HLT_MS_FALL_START: begin
            mono = 1'b1;
            start_kind = hlt_pkg::HLT_EDGE_FALL;
          end
          hlt_pkg::HLT_MS_ANY_START: begin
            mono = 1'b1;
            start_kind = hlt_pkg::HLT_EDGE_ANY;
          end
          hlt_pkg::HLT_LV_HIGH_RUN: begin
            one_shot = 1'b1;
            gate_ok = ers_level;
            lvl_rst = ~ers_level;
          end
          hlt_pkg::HLT_LV_LOW_RUN: begin
            one_shot = 1'b1;
            gate_ok = ~ers_level;
            lvl_rst = ers_level;
          end
          default: reserved = 1'b1;
        endcase
      end
      default: reserved = 1'b1;
    endcase

    // Start edge only counts while enabled and not yet started
    start_ev = st_q.on & ~st_q.started &
               edge_hit(start_kind, rise_v, fall_v);

    // External reset: level or edge, only while enabled, never frozen
    rst_active = st_q.on & ~reserved & ~debug_freeze &
                 (~rst_needs_start | st_q.started |
                  (start_kind == hlt_pkg::HLT_EDGE_NONE)) &
                 (lvl_rst | (st_q.started &
                  edge_hit(rst_edge_kind, rise_v, fall_v)) |
                  ((start_kind == hlt_pkg::HLT_EDGE_NONE) &
                  edge_hit(rst_edge_kind, rise_v, fall_v)));

    // Counting needs enable, gate level and, if edge-started, a start
    run = st_q.on & gate_ok & ~reserved & ~debug_freeze & ~rst_active &
          ((start_kind == hlt_pkg::HLT_EDGE_NONE) | st_q.started);

    // Period match seen by the postscaler and the PWM unit
    match = run & (st_q.count == st_q.period) & ~count_wr.wr;

    // Edge-start qualifier, lost whenever enable drops
    if (!st_q.on) begin
      st_d.started = 1'b0;
    end else if (start_ev) begin
      st_d.started = 1'b1;
    end else if (match && (one_shot || mono)) begin
      st_d.started = 1'b0;
    end

    // Enable: software write wins over the hardware clear at match
    if (ctrl.ctrl_wr) begin
      st_d.on = ctrl.on_wdata;
      st_d.started = 1'b0;
    end else if (match && one_shot) begin
      st_d.on = 1'b0;
    end

    // Count value
    if (count_wr.wr) begin
      st_d.count = count_wr.wdata;
    end else if (rst_active) begin
      st_d.count = hlt_pkg::HLT_COUNT_RST;
    end else if (match) begin
      st_d.count = hlt_pkg::HLT_COUNT_RST;
    end else if (run) begin
      st_d.count = st_q.count + hlt_pkg::HLT_COUNT_ONE;
    end

    // Period value
    if (period_wr.wr) begin
      st_d.period = period_wr.wdata;
    end

    // Postscaler and its output pulse
    clr_post = ctrl.ctrl_wr | count_wr.wr | rst_active;
    st_d.pulse = 1'b0;
    if (clr_post) begin
      st_d.post_cnt = hlt_pkg::HLT_POST_RST;
    end else if (match) begin
      if (st_q.post_cnt == ctrl.postscale_select) begin
        st_d.pulse = 1'b1;
        st_d.post_cnt = hlt_pkg::HLT_POST_RST;
      end else begin
        st_d.post_cnt = st_q.post_cnt + hlt_pkg::HLT_POST_ONE;
      end
    end
  end

  // State register with device reset values
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q.count <= hlt_pkg::HLT_COUNT_RST;
      st_q.period <= hlt_pkg::HLT_PERIOD_RST;
      st_q.post_cnt <= hlt_pkg::HLT_POST_RST;
      st_q.on <= 1'b0;
      st_q.started <= 1'b0;
      st_q.pulse <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Time base for the PWM unit
  assign pwm_base.count_value = st_q.count;
  assign pwm_base.period_value = st_q.period;
  assign pwm_base.period_match = match;
  assign pwm_base.counting = run;

  // Exported pulse and status
  assign period_match_pulse = st_q.pulse;
  assign on_status = st_q.on;
  assign ers_reset_active = rst_active;

endmodule

// *** hlt_timer_asserts.sv ***
// Concurrent checks on the ports of the hardware-limit timer
`timescale 1ns/100ps
module hlt_timer_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Inputs of the timer
  input wire hlt_pkg::hlt_ctrl_t ctrl,
  input wire hlt_pkg::hlt_wr_t count_wr,
  input wire hlt_pkg::hlt_wr_t period_wr,
  input wire logic debug_freeze,
  input wire logic [hlt_pkg::HLT_NUM_SRC-1:0] ext_reset_sources,
  input wire logic [hlt_pkg::HLT_SEL_W-1:0] reset_source_select,
  // Outputs of the timer
  input wire logic on_status,
  input wire hlt_pkg::hlt_pwm_t pwm_base,
  input wire logic period_match_pulse,
  input wire logic ers_reset_active
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  // No write and no external reset overriding the count
  logic quiet;
  assign quiet = !count_wr.wr && !ers_reset_active;
  // Period match in a mode that ends by clearing enable
  sequence s_os_match;
    pwm_base.period_match && !ctrl.ctrl_wr && quiet &&
    (ctrl.mode[4:3] == hlt_pkg::HLT_GRP_ONESHOT ||
     ctrl.mode[4:1] == 4'HB);
  endsequence
  // Period match in an edge-started monostable mode
  sequence s_ms_match;
    pwm_base.period_match && !ctrl.ctrl_wr && quiet &&
    ctrl.mode[4:3] == hlt_pkg::HLT_GRP_MONO &&
    ctrl.mode[2:0] inside {3'H1, 3'H2, 3'H3};
  endsequence
  // Count parked at zero
  sequence s_at_zero;
    pwm_base.count_value == 8'H00;
  endsequence
  a_wrap_zero: assert property (
    pwm_base.period_match && quiet |=> s_at_zero)
    else $error("count did not wrap after match");
  a_count_step: assert property (
    pwm_base.counting && !pwm_base.period_match && quiet |=>
    pwm_base.count_value == $past(pwm_base.count_value) + 8'H01)
    else $error("count did not advance by one");
  a_hold_idle: assert property (
    !pwm_base.counting && quiet |=> $stable(pwm_base.count_value))
    else $error("count moved while stopped");
  a_count_load: assert property (
    count_wr.wr |=> pwm_base.count_value == $past(count_wr.wdata))
    else $error("count write not taken");
  a_period_load: assert property (
    period_wr.wr |=> pwm_base.period_value == $past(period_wr.wdata))
    else $error("period write not taken");
  a_on_load: assert property (
    ctrl.ctrl_wr |=> on_status == $past(ctrl.on_wdata))
    else $error("enable write not taken");
  a_off_still: assert property (
    !on_status |-> !pwm_base.counting)
    else $error("counting with enable clear");
  a_freeze_quiet: assert property (
    debug_freeze |-> !pwm_base.counting && !ers_reset_active)
    else $error("activity during freeze");
  a_pulse_cause: assert property (
    period_match_pulse |-> $past(pwm_base.period_match))
    else $error("pulse without a match");
  a_pulse_single: assert property (
    period_match_pulse && ctrl.postscale_select != 4'H0 |=>
    !period_match_pulse)
    else $error("pulse wider than one clock");
  a_oneshot_end: assert property (
    s_os_match |=> (!on_status and s_at_zero))
    else $error("one-shot did not stop at zero");
  a_mono_end: assert property (
    s_ms_match |=> (on_status and s_at_zero))
    else $error("monostable did not park at zero");
endmodule

bind hlt_timer hlt_timer_asserts u_asserts (
  .clk_sys(clk_sys),
  .arst_n(arst_n),
  .ctrl(ctrl),
  .count_wr(count_wr),
  .period_wr(period_wr),
  .debug_freeze(debug_freeze),
  .ext_reset_sources(ext_reset_sources),
  .reset_source_select(reset_source_select),
  .on_status(on_status),
  .pwm_base(pwm_base),
  .period_match_pulse(period_match_pulse),
  .ers_reset_active(ers_reset_active)
);

// *** hlt_ers_model.sv ***
// Model of the reset-source logic feeding the timer
`timescale 1ns/100ps
module hlt_ers_model (
  // Clock
  input wire logic clk_sys,
  // Requested level and the line it appears on
  input wire logic want_lvl,
  input wire logic [4:0] sel,
  // Source lines and request done
  output logic [31:0] srcs,
  output logic settled
);
  logic lvl_q;
  logic [3:0] gap_q;
  logic [31:0] noise_q;
  initial begin
    lvl_q = 1'b0;
    gap_q = 4'H0;
    noise_q = 32'H0;
  end
  // Unused lines toggle; changes keep a safe spacing
  always @(posedge clk_sys) begin
    noise_q <= ~noise_q;
    if (gap_q != 4'HF) gap_q <= gap_q + 4'H1;
    if (want_lvl != lvl_q && gap_q >= 4'H8) begin
      lvl_q <= want_lvl;
      gap_q <= 4'H0;
    end
  end
  // Selected line carries the level
  always_comb begin
    srcs = noise_q;
    srcs[sel] = lvl_q;
  end
  assign settled = (want_lvl == lvl_q);
endmodule

// *** test_hlt_timer.sv ***
// Self-checking bench for the hardware-limit timer
`timescale 1ns/100ps
module test_hlt_timer;
  logic clk_sys;
  logic arst_n;
  hlt_pkg::hlt_ctrl_t ctrl;
  hlt_pkg::hlt_wr_t count_wr;
  hlt_pkg::hlt_wr_t period_wr;
  logic debug_freeze;
  logic want_lvl;
  logic [4:0] sel;
  logic [31:0] srcs;
  logic settled;
  logic on_status;
  hlt_pkg::hlt_pwm_t pwm_base;
  logic period_match_pulse;
  logic ers_reset_active;
  int n_fail;
  int comparisons;
  // Timer and its reset source
  hlt_timer u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .ctrl(ctrl),
    .count_wr(count_wr), .period_wr(period_wr),
    .debug_freeze(debug_freeze), .ext_reset_sources(srcs),
    .reset_source_select(sel), .on_status(on_status),
    .pwm_base(pwm_base), .period_match_pulse(period_match_pulse),
    .ers_reset_active(ers_reset_active));
  hlt_ers_model u_src (.clk_sys(clk_sys), .want_lvl(want_lvl),
    .sel(sel), .srcs(srcs), .settled(settled));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr_ctrl(input logic on, input logic [4:0] md,
                         input logic [3:0] ps);
    @(posedge clk_sys);
    ctrl <= '{1'b1, on, md, ps};
    @(posedge clk_sys);
    ctrl.ctrl_wr <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic wr_cnt(input logic per, input logic [7:0] v);
    @(posedge clk_sys);
    if (per) period_wr <= '{1'b1, v};
    else count_wr <= '{1'b1, v};
    @(posedge clk_sys);
    period_wr.wr <= 1'b0;
    count_wr.wr <= 1'b0;
    @(negedge clk_sys);
  endtask
  // Move the selected line, then let the synchroniser catch up
  task automatic set_ers(input logic l);
    int i;
    @(posedge clk_sys);
    want_lvl <= l;
    for (i = 0; i < 16; i++) begin
      @(negedge clk_sys);
      if (settled === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      final_report();
    end
    tick(6);
  endtask
  task automatic wait_pulse(output int n);
    for (n = 1; n <= 300; n++) begin
      @(negedge clk_sys);
      if (period_match_pulse === 1'b1) return;
    end
    n_fail++;
    final_report();
  endtask
  // Did the count move over three clocks
  task automatic chk_run(input string nm, input logic exp);
    logic [7:0] a;
    a = pwm_base.count_value;
    tick(3);
    chk(nm, {7'H00, exp}, {7'H00, a !== pwm_base.count_value});
  endtask
  task automatic mode_run(input logic [4:0] md, input logic l,
                          input logic exp);
    set_ers(l);
    wr_ctrl(1'b1, md, 4'H0);
    tick(2);
    chk_run($sformatf("run %b", md), exp);
  endtask
  task automatic edge_rst(input logic [4:0] md, input logic f,
                          input logic t, input logic exp);
    set_ers(f);
    wr_ctrl(1'b1, md, 4'H0);
    wr_cnt(1'b0, 8'H00);
    tick(24);
    set_ers(t);
    chk($sformatf("reset %b", md), {7'H00, exp},
        {7'H00, pwm_base.count_value < 8'H10});
  endtask
  task automatic start_edge(input logic [4:0] md, input logic f,
                            input logic t, input logic exp);
    set_ers(f);
    wr_ctrl(1'b1, md, 4'H0);
    wr_cnt(1'b0, 8'H00);
    chk_run($sformatf("idle %b", md), 1'b0);
    set_ers(t);
    chk_run($sformatf("start %b", md), exp);
  endtask
  task automatic t_regs();
    wr_ctrl(1'b0, 5'H00, 4'H0);
    wr_cnt(1'b0, 8'H5A);
    wr_ctrl(1'b0, 5'H00, 4'H0);
    chk("count kept", 8'H5A, pwm_base.count_value);
    $display("done registers");
  endtask
  task automatic t_post();
    int n;
    wr_cnt(1'b1, 8'H02);
    for (int ps = 0; ps < 8; ps += 3) begin
      wr_ctrl(1'b1, 5'H00, ps[3:0]);
      wait_pulse(n);
      wait_pulse(n);
      chk("pulse gap", 8'(3 * (ps + 1)), 8'(n));
    end
    wr_cnt(1'b1, 8'HFF);
    $display("done postscaler");
  endtask
  task automatic t_levels();
    mode_run(5'H01, 1'b1, 1'b1);
    mode_run(5'H01, 1'b0, 1'b0);
    mode_run(5'H02, 1'b0, 1'b1);
    mode_run(5'H02, 1'b1, 1'b0);
    mode_run(5'H06, 1'b0, 1'b0);
    mode_run(5'H06, 1'b1, 1'b1);
    mode_run(5'H07, 1'b1, 1'b0);
    mode_run(5'H07, 1'b0, 1'b1);
    mode_run(5'H10, 1'b1, 1'b0);
    mode_run(5'H14, 1'b1, 1'b0);
    mode_run(5'H15, 1'b0, 1'b0);
    mode_run(5'H18, 1'b0, 1'b0);
    mode_run(5'H08, 1'b0, 1'b1);
    mode_run(5'H00, 1'b1, 1'b1);
    // Move the level to another source line; the old one turns to noise
    @(posedge clk_sys);
    sel <= 5'H05;
    mode_run(5'H01, 1'b1, 1'b1);
    mode_run(5'H01, 1'b0, 1'b0);
    @(posedge clk_sys);
    debug_freeze <= 1'b1;
    tick(1);
    chk("freeze counting", 8'H00, {7'H00, pwm_base.counting});
    chk_run("freeze", 1'b0);
    @(posedge clk_sys);
    debug_freeze <= 1'b0;
    $display("done levels");
  endtask
  task automatic t_edges();
    edge_rst(5'H03, 1'b0, 1'b1, 1'b1);
    edge_rst(5'H03, 1'b1, 1'b0, 1'b1);
    edge_rst(5'H04, 1'b0, 1'b1, 1'b1);
    edge_rst(5'H04, 1'b1, 1'b0, 1'b0);
    edge_rst(5'H05, 1'b1, 1'b0, 1'b1);
    edge_rst(5'H05, 1'b0, 1'b1, 1'b0);
    start_edge(5'H09, 1'b0, 1'b1, 1'b1);
    start_edge(5'H09, 1'b1, 1'b0, 1'b0);
    start_edge(5'H0A, 1'b1, 1'b0, 1'b1);
    start_edge(5'H0B, 1'b1, 1'b0, 1'b1);
    start_edge(5'H11, 1'b0, 1'b1, 1'b1);
    start_edge(5'H12, 1'b1, 1'b0, 1'b1);
    start_edge(5'H13, 1'b0, 1'b1, 1'b1);
    start_edge(5'H16, 1'b0, 1'b1, 1'b1);
    start_edge(5'H17, 1'b1, 1'b0, 1'b1);
    $display("done edges");
  endtask
  task automatic t_hw_oneshot();
    start_edge(5'H0C, 1'b0, 1'b1, 1'b1);
    tick(20);
    set_ers(1'b0);
    set_ers(1'b1);
    chk("edge reset", 8'H01, {7'H00, pwm_base.count_value < 8'H10});
    start_edge(5'H0D, 1'b1, 1'b0, 1'b1);
    start_edge(5'H0E, 1'b0, 1'b1, 1'b1);
    set_ers(1'b0);
    chk("reset active", 8'H01, {7'H00, ers_reset_active});
    chk_run("low reset", 1'b0);
    start_edge(5'H0F, 1'b1, 1'b0, 1'b1);
    wr_ctrl(1'b0, 5'H09, 4'H0);
    wr_ctrl(1'b1, 5'H09, 4'H0);
    chk_run("no resume", 1'b0);
    set_ers(1'b1);
    chk_run("resume", 1'b1);
    $display("done hardware one-shot");
  endtask
  task automatic t_ends();
    int n;
    wr_cnt(1'b1, 8'H20);
    wr_cnt(1'b0, 8'H00);
    wr_ctrl(1'b1, 5'H08, 4'H0);
    wait_pulse(n);
    tick(2);
    chk("one-shot on", 8'H00, {7'H00, on_status});
    chk("one-shot count", 8'H00, pwm_base.count_value);
    start_edge(5'H11, 1'b0, 1'b1, 1'b1);
    wait_pulse(n);
    tick(2);
    chk("mono on", 8'H01, {7'H00, on_status});
    chk_run("mono parked", 1'b0);
    set_ers(1'b0);
    set_ers(1'b1);
    chk_run("mono again", 1'b1);
    $display("done one-shot ends");
  endtask
  // Main sequence
  initial begin
    ctrl = '0;
    count_wr = '0;
    period_wr = '0;
    debug_freeze = 1'b0;
    want_lvl = 1'b0;
    sel = 5'H13;
    n_fail = 0;
    comparisons = 0;
    arst_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    tick(1);
    chk("count reset", 8'H00, pwm_base.count_value);
    chk("period reset", 8'HFF, pwm_base.period_value);
    chk("on reset", 8'H00, {7'H00, on_status});
    t_regs();
    t_post();
    t_levels();
    t_edges();
    t_hw_oneshot();
    t_ends();
    final_report();
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    final_report();
  end
endmodule
